// ---- design/adc_cfg_defines.svh ----
// Purpose: offsets, field positions, reset values and opcodes of the config bank
// Assumes: serial commands are one byte, registers are one byte each
// Notes:   definitions only
`ifndef ADC_CFG_DEFINES_SVH
`define ADC_CFG_DEFINES_SVH

// register indices on the serial port
`define REG_INPUT_GAIN        2'h0
`define REG_RATE_MODE         2'h1
`define REG_REF_EXC           2'h2
`define REG_SOURCE_ROUTE      2'h3
`define REG_RESET_VALUE       8'h00

// rate_mode_config fields
`define RATE_SELECT_HI        7
`define RATE_SELECT_LO        5
`define OP_MODE_HI            4
`define OP_MODE_LO            3
`define CONTINUOUS_BIT        2
`define TEMP_SENSOR_BIT       1
`define BURNOUT_BIT           0

// reference_excitation_config fields
`define REF_SEL_HI            7
`define REF_SEL_LO            6
`define MAINS_SEL_HI          5
`define MAINS_SEL_LO          4
`define LOW_SIDE_BIT          3
`define EXC_LEVEL_HI          2
`define EXC_LEVEL_LO          0

// source_routing_config fields
`define FIRST_ROUTE_HI        7
`define FIRST_ROUTE_LO        5
`define SECOND_ROUTE_HI       4
`define SECOND_ROUTE_LO       2
`define READY_OUT_BIT         1
`define RESERVED_BIT          0

// operating modes and special codes
`define MODE_NORMAL           2'h0
`define MODE_DUTY             2'h1
`define MODE_TURBO            2'h2
`define RATE_SLOWEST          3'h0
`define CODE_UNUSED3          3'h7
`define MOD_CLK_NORMAL_KHZ    10'h100
`define MOD_CLK_TURBO_KHZ     10'h200

// command opcodes (upper bits compared)
`define CMD_WRITE_NIB         4'h4
`define CMD_READ_NIB          4'h2
`define CMD_START_TOP         7'h04
`define CMD_SLEEP_TOP         7'h01
`define CMD_RESET_TOP         7'h03
`define BITS_PER_BYTE         3'h7

`endif

// ---- design/adc_cfg_pkg.sv ----
// Purpose: shared types of the configuration bank
// Assumes: nothing beyond the defines header
// Notes:   types only, constants live in the header
package adc_cfg_pkg;

   // serial transfer phase
   typedef enum logic [1:0] {
      PH_CMD   = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ  = 2'b10
   } phase_e;

   typedef logic [3:0][7:0] bank_t;   // four config bytes

endpackage : adc_cfg_pkg

// ---- design/spi_pin_sampler.sv ----
// Purpose: brings the serial pins into the core clock and finds sclk edges
// Assumes: pins are asynchronous to CLOCK_I, sclk much slower than the clock
// Notes:   edges come from the second and third stage, never the first
`timescale 1ns/1ps
module spi_pin_sampler
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // raw pins
   input  wire logic cs_n_i,
   input  wire logic sclk_i,
   input  wire logic din_i,
   // synchronised view
   output logic      cs_n_o,
   output logic      din_o,
   output logic      sclk_rise_o,
   output logic      sclk_fall_o
);

   // all sampler state in one word: [1:0] cs, [2:0] sclk, [1:0] din
   typedef struct packed {
      logic [1:0] cs;     // two stage cs chain
      logic [2:0] sclk;   // two stages plus one for edge finding
      logic [1:0] din;    // two stage data chain
   } samp_s;

   samp_s st_r;
   samp_s st_nxt;

   // shift each pin along its chain
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.cs   = {st_r.cs[0], cs_n_i};
      st_nxt.sclk = {st_r.sclk[1:0], sclk_i};
      st_nxt.din  = {st_r.din[0], din_i};
   end

   // cs resets high so the port starts deselected
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_r <= '{cs: 2'h3, sclk: 3'h0, din: 2'h0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign cs_n_o      = st_r.cs[1];
   assign din_o       = st_r.din[1];
   assign sclk_rise_o = st_r.sclk[1] & ~st_r.sclk[2];
   assign sclk_fall_o = ~st_r.sclk[1] & st_r.sclk[2];

endmodule : spi_pin_sampler

// ---- design/adc_config_registers.sv ----
// Purpose: configuration registers 1..3 of the sensor converter, serial port
// Assumes: host is an spi mode 1 master, sclk far slower than CLOCK_I
// Notes:   decoded settings leave as registered ports for the analog side
`timescale 1ns/1ps
`include "adc_cfg_defines.svh"

// What this block does
// [RULE1] normal mode rates 20 to 1000 sps
// [RULE2] duty-cycle mode rates 5 to 250 sps
// [RULE3] turbo mode rates 40 to 2000 sps
// [RULE4] mode field picks normal, duty or turbo
// [RULE5] bit two picks single or continuous
// [RULE6] bit one enables temperature sensor mode
// [RULE7] bit zero switches burn-out sources
// [RULE8] reference field picks one of four
// [RULE9] mains filter only at slowest rate
// [RULE10] mains field picks rejection coefficients
// [RULE11] low-side switch follows start and sleep
// [RULE12] one current level for both sources
// [RULE13] first source routing field
// [RULE14] second source routing, same mapping
// [RULE15] ready also on serial output if set
// [RULE16] serial port runs spi mode one
// [RULE17] launch on rising, sample on falling
// [RULE18] host writes zero to reserved bit
// [RULE19] read and write commands carry address, count
// [RULE20] writes take effect on final falling edge
// [RULE21] write completion restarts the filter
module adc_config_registers
   import adc_cfg_pkg::*;
(
   // clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RESET_I,
   // serial pins from the host
   input  wire logic        CS_N_I,
   input  wire logic        SCLK_I,
   input  wire logic        DIN_I,
   output logic             DOUT_O,
   output logic             DOUT_OE_O,
   // conversion side
   input  wire logic        CONV_DONE_I,
   output logic             DATA_READY_N_O,
   output logic             START_PULSE_O,
   output logic             FILTER_RESTART_O,
   // decoded settings
   output logic [13:0]      RATE_QSPS_O,
   output logic [9:0]       MOD_CLK_KHZ_O,
   output logic             DUTY_CYCLE_O,
   output logic             CONTINUOUS_O,
   output logic             TEMP_SENSOR_O,
   output logic             BURNOUT_O,
   output logic [1:0]       REF_SEL_O,
   output logic [1:0]       MAINS_FILTER_O,
   output logic             LOW_SIDE_CLOSED_O,
   output logic [10:0]      EXC_CURRENT_UA_O,
   output logic [2:0]       FIRST_ROUTE_O,
   output logic [2:0]       SECOND_ROUTE_O,
   output logic             POWERED_DOWN_O
);

   // whole block state
   typedef struct packed {
      bank_t       cfg;          // live registers
      bank_t       pend;         // staged write bytes
      phase_e      phase;        // serial phase
      logic [2:0]  bitcnt;       // bit within byte
      logic [7:0]  rx;           // inbound shift
      logic [7:0]  tx;           // outbound shift
      logic [1:0]  addr;         // current register
      logic [1:0]  left;         // bytes still to move
      logic        dout;         // serial out level
      logic        dout_oe;      // serial out driven
      logic        ready_n;      // data ready, low active
      logic        start;        // start command pulse
      logic        restart;      // filter restart pulse
      logic        sw_closed;    // switch request state
      logic        sleep;        // powered down
      logic [13:0] rate_q;       // rate in quarter sps
      logic [9:0]  mod_khz;      // modulator clock
      logic [1:0]  mains;        // effective mains filter
      logic [10:0] exc_ua;       // excitation current
      logic [2:0]  route1;       // first source route
      logic [2:0]  route2;       // second source route
      logic        sw_out;       // switch output
      logic        duty;         // duty-cycle mode flag
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // synchronised pins
   logic cs_n_s;
   logic din_s;
   logic sclk_rise;
   logic sclk_fall;

   // pins pass two flops before use
   spi_pin_sampler u_pins
   (
      .clk_i       (CLOCK_I),
      .rst_i       (RESET_I),
      .cs_n_i      (CS_N_I),
      .sclk_i      (SCLK_I),
      .din_i       (DIN_I),
      .cs_n_o      (cs_n_s),
      .din_o       (din_s),
      .sclk_rise_o (sclk_rise),
      .sclk_fall_o (sclk_fall)
   );

   // rate in quarter sps so that 11.25 and 22.5 stay exact; zero when unused
   function automatic logic [13:0] rate_lookup(input logic [1:0] mode,
                                               input logic [2:0] code);
      logic [13:0] r;
      r = 14'h0000;
      case (mode)
         `MODE_NORMAL:
         begin
            case (code)                                          // RULE1
               3'h0: r = 14'h0050;
               3'h1: r = 14'h00B4;
               3'h2: r = 14'h0168;
               3'h3: r = 14'h02BC;
               3'h4: r = 14'h0528;
               3'h5: r = 14'h0960;
               3'h6: r = 14'h0FA0;
               default: r = 14'h0000;
            endcase
         end
         `MODE_DUTY:
         begin
            case (code)                                          // RULE2
               3'h0: r = 14'h0014;
               3'h1: r = 14'h002D;
               3'h2: r = 14'h005A;
               3'h3: r = 14'h00B0;
               3'h4: r = 14'h014A;
               3'h5: r = 14'h0258;
               3'h6: r = 14'h03E8;
               default: r = 14'h0000;
            endcase
         end
         `MODE_TURBO:
         begin
            case (code)                                          // RULE3
               3'h0: r = 14'h00A0;
               3'h1: r = 14'h0168;
               3'h2: r = 14'h02D0;
               3'h3: r = 14'h0578;
               3'h4: r = 14'h0A50;
               3'h5: r = 14'h12C0;
               3'h6: r = 14'h1F40;
               default: r = 14'h0000;
            endcase
         end
         default: r = 14'h0000;
      endcase
      return r;
   endfunction : rate_lookup

   // excitation current in microamps, code one is unused and reads as off
   function automatic logic [10:0] current_lookup(input logic [2:0] code);
      logic [10:0] c;
      c = 11'h000;
      case (code)                                                // RULE12
         3'h2: c = 11'h032;
         3'h3: c = 11'h064;
         3'h4: c = 11'h0FA;
         3'h5: c = 11'h1F4;
         3'h6: c = 11'h3E8;
         3'h7: c = 11'h5DC;
         default: c = 11'h000;
      endcase
      return c;
   endfunction : current_lookup

   // routing code 111 is unused; treat it as disabled
   function automatic logic [2:0] route_clean(input logic [2:0] code);
      return (code == `CODE_UNUSED3) ? 3'h0 : code;
   endfunction : route_clean

   // serial engine and settings decode
   always_comb
   begin
      logic [7:0] rx_byte;
      logic [7:0] r1;
      logic [7:0] r2;
      logic [7:0] r3;
      rx_byte        = {st_r.rx[6:0], din_s};
      r1             = st_r.cfg[`REG_RATE_MODE];
      r2             = st_r.cfg[`REG_REF_EXC];
      r3             = st_r.cfg[`REG_SOURCE_ROUTE];
      st_nxt         = st_r;
      st_nxt.start   = 1'b0;
      st_nxt.restart = 1'b0;

      if (cs_n_s)
      begin
         // deselected: abandon any transfer
         st_nxt.phase  = PH_CMD;
         st_nxt.bitcnt = 3'h0;
      end
      else
      begin
         // mode 1: launch the next read bit on rising edges
         if (sclk_rise && st_r.phase == PH_READ)                 // RULE17
         begin
            st_nxt.dout = st_r.tx[7];
            st_nxt.tx   = {st_r.tx[6:0], 1'b0};
         end
         // mode 1: sample din on falling edges
         if (sclk_fall)                                          // RULE16
         begin
            st_nxt.rx     = rx_byte;                             // RULE17
            st_nxt.bitcnt = st_r.bitcnt + 3'h1;
            if (st_r.bitcnt == `BITS_PER_BYTE)
            begin
               case (st_r.phase)
                  PH_CMD:
                  begin
                     // opcode with address and count in low nibble
                     st_nxt.addr = rx_byte[3:2];                 // RULE19
                     st_nxt.left = rx_byte[1:0];
                     if (rx_byte[7:4] == `CMD_WRITE_NIB)
                     begin
                        st_nxt.phase = PH_WRITE;
                        st_nxt.pend  = st_r.cfg;
                     end
                     else if (rx_byte[7:4] == `CMD_READ_NIB)
                     begin
                        st_nxt.phase = PH_READ;
                        st_nxt.tx    = st_r.cfg[rx_byte[3:2]];
                     end
                     else if (rx_byte[7:1] == `CMD_START_TOP)
                     begin
                        st_nxt.start     = 1'b1;
                        st_nxt.sleep     = 1'b0;
                        st_nxt.sw_closed = 1'b1;                 // RULE11
                     end
                     else if (rx_byte[7:1] == `CMD_SLEEP_TOP)
                     begin
                        st_nxt.sleep     = 1'b1;
                        st_nxt.sw_closed = 1'b0;                 // RULE11
                     end
                     else if (rx_byte[7:1] == `CMD_RESET_TOP)
                     begin
                        st_nxt.cfg = '0;
                     end
                  end
                  PH_WRITE:
                  begin
                     // reserved bit is dropped whatever the host sent
                     st_nxt.pend[st_r.addr] = rx_byte;
                     if (st_r.addr == `REG_SOURCE_ROUTE)
                     begin
                        st_nxt.pend[st_r.addr][`RESERVED_BIT] = 1'b0; // RULE18
                     end
                     if (st_r.left == 2'h0)
                     begin
                        // last falling edge: commit all bytes at once
                        st_nxt.cfg     = st_nxt.pend;            // RULE20
                        st_nxt.restart = 1'b1;                   // RULE21
                        st_nxt.phase   = PH_CMD;
                     end
                     else
                     begin
                        st_nxt.addr = st_r.addr + 2'h1;
                        st_nxt.left = st_r.left - 2'h1;
                     end
                  end
                  PH_READ:
                  begin
                     // commands are not decoded until the read ends
                     if (st_r.left == 2'h0)
                     begin
                        st_nxt.phase = PH_CMD;
                     end
                     else
                     begin
                        st_nxt.addr = st_r.addr + 2'h1;
                        st_nxt.left = st_r.left - 2'h1;
                        st_nxt.tx   = st_r.cfg[st_r.addr + 2'h1];
                     end
                  end
                  default: st_nxt.phase = PH_CMD;
               endcase
            end
         end
      end

      // ready falls on a finished conversion; a new set wins over the clear
      if (CONV_DONE_I)
      begin
         st_nxt.ready_n = 1'b0;
      end
      else if (sclk_fall && !cs_n_s && st_r.bitcnt == `BITS_PER_BYTE)
      begin
         st_nxt.ready_n = 1'b1;
      end

      // serial out pin: read data, else ready when READY_OUT_BIT is set, else idle high
      st_nxt.dout_oe = ~cs_n_s;
      if (st_nxt.phase != PH_READ)
      begin
         st_nxt.dout = r3[`READY_OUT_BIT] ? st_nxt.ready_n : 1'b1; // RULE15
      end

      // settings decode, one cycle behind the live registers
      st_nxt.rate_q = rate_lookup(r1[`OP_MODE_HI:`OP_MODE_LO],
                                  r1[`RATE_SELECT_HI:`RATE_SELECT_LO]);
      case (r1[`OP_MODE_HI:`OP_MODE_LO])                         // RULE4
         `MODE_NORMAL: st_nxt.mod_khz = `MOD_CLK_NORMAL_KHZ;
         `MODE_DUTY:   st_nxt.mod_khz = `MOD_CLK_NORMAL_KHZ;
         `MODE_TURBO:  st_nxt.mod_khz = `MOD_CLK_TURBO_KHZ;
         default:      st_nxt.mod_khz = 10'h000;
      endcase
      // mains coefficients only mean something at the slowest normal/duty rate
      if (r1[`RATE_SELECT_HI:`RATE_SELECT_LO] == `RATE_SLOWEST &&
          (r1[`OP_MODE_HI:`OP_MODE_LO] == `MODE_NORMAL ||
           r1[`OP_MODE_HI:`OP_MODE_LO] == `MODE_DUTY))           // RULE9
      begin
         st_nxt.mains = r2[`MAINS_SEL_HI:`MAINS_SEL_LO];          // RULE10
      end
      else
      begin
         st_nxt.mains = 2'h0;
      end
      // sleep turns both sources off but keeps the registers
      st_nxt.exc_ua = st_r.sleep ? 11'h000
                                 : current_lookup(r2[`EXC_LEVEL_HI:`EXC_LEVEL_LO]);
      st_nxt.route1 = route_clean(r3[`FIRST_ROUTE_HI:`FIRST_ROUTE_LO]);   // RULE13
      st_nxt.route2 = route_clean(r3[`SECOND_ROUTE_HI:`SECOND_ROUTE_LO]); // RULE14
      st_nxt.sw_out = r2[`LOW_SIDE_BIT] & st_r.sw_closed;        // RULE11
      st_nxt.duty   = (r1[`OP_MODE_HI:`OP_MODE_LO] == `MODE_DUTY); // RULE4
   end

   // one register for the whole state
   always_ff @(posedge CLOCK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         st_r         <= '0;
         st_r.phase   <= PH_CMD;
         st_r.dout    <= 1'b1;
         st_r.ready_n <= 1'b1;
         st_r.rate_q  <= 14'h0050;
         st_r.mod_khz <= `MOD_CLK_NORMAL_KHZ;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ports straight from the state register
   assign DOUT_O            = st_r.dout;
   assign DOUT_OE_O         = st_r.dout_oe;
   assign DATA_READY_N_O    = st_r.ready_n;
   assign START_PULSE_O     = st_r.start;
   assign FILTER_RESTART_O  = st_r.restart;
   assign RATE_QSPS_O       = st_r.rate_q;
   assign MOD_CLK_KHZ_O     = st_r.mod_khz;
   assign DUTY_CYCLE_O      = st_r.duty;
   assign CONTINUOUS_O      = st_r.cfg[`REG_RATE_MODE][`CONTINUOUS_BIT];   // RULE5
   assign TEMP_SENSOR_O     = st_r.cfg[`REG_RATE_MODE][`TEMP_SENSOR_BIT];  // RULE6
   assign BURNOUT_O         = st_r.cfg[`REG_RATE_MODE][`BURNOUT_BIT];      // RULE7
   assign REF_SEL_O         = st_r.cfg[`REG_REF_EXC][`REF_SEL_HI:`REF_SEL_LO]; // RULE8
   assign MAINS_FILTER_O    = st_r.mains;
   assign LOW_SIDE_CLOSED_O = st_r.sw_out;
   assign EXC_CURRENT_UA_O  = st_r.exc_ua;
   assign FIRST_ROUTE_O     = st_r.route1;
   assign SECOND_ROUTE_O    = st_r.route2;
   assign POWERED_DOWN_O    = st_r.sleep;

   // checks
   a_rate_normal_slow: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE1
      (st_r.cfg[1][7:3] == 5'h00) |=> (RATE_QSPS_O == 14'h0050))
      else $error("normal slowest rate not 20 sps");
   a_rate_duty_fast: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE2
      (st_r.cfg[1][7:3] == 5'h19) |=> (RATE_QSPS_O == 14'h03E8))
      else $error("duty fastest rate not 250 sps");
   a_rate_turbo_fast: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE3
      (st_r.cfg[1][7:3] == 5'h1A) |=> (RATE_QSPS_O == 14'h1F40))
      else $error("turbo fastest rate not 2000 sps");
   a_mode_turbo_clk: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE4
      (st_r.cfg[1][4:3] == 2'h2) |=> (MOD_CLK_KHZ_O == 10'h200))
      else $error("turbo modulator clock wrong");
   a_mains_gated: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE9
      (MAINS_FILTER_O != 2'h0) |-> ($past(st_r.cfg[1][7:5]) == 3'h0))
      else $error("mains filter active at a faster rate");
   a_switch_open: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE11
      (st_r.cfg[2][3] == 1'b0) |=> !LOW_SIDE_CLOSED_O)
      else $error("low-side switch closed while disabled");
   a_commit_edge: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE20
      ($past(st_r.phase) == PH_WRITE && $changed(st_r.cfg)) |-> $past(sclk_fall))
      else $error("config changed away from a falling edge");
   a_restart_once: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE21
      FILTER_RESTART_O |-> ($past(st_r.phase) == PH_WRITE) ##1 !FILTER_RESTART_O)
      else $error("filter restart not a single pulse after a write");
   a_ready_pin_off: assert property (@(posedge CLOCK_I) disable iff (RESET_I) // RULE15
      (st_r.cfg[3][1] == 1'b0 && st_nxt.phase != PH_READ) |=> DOUT_O)
      else $error("serial output not idle high with ready mode off");

endmodule : adc_config_registers

// ---- test/spi_host_model.sv ----
// Purpose: host side spi mode 1 master for the config bank
// Assumes: core clock of 10 ns, sclk period of 16 core cycles
// Notes:   sclk stands low outside frames, din toggles when released
`timescale 1ns/1ps
module spi_host_model
(
   // clock
   input  wire logic clk_i,
   // serial pins
   output logic      cs_n_o,
   output logic      sclk_o,
   output logic      din_o,
   input  wire logic dout_i
);
   // idle: deselected, clock low
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      din_o  = 1'b0;
   end

   // select the device, leaving setup time before the first edge
   task automatic open_frame();
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (8) @(posedge clk_i);
   endtask : open_frame

   // release select; din must not keep its last level
   task automatic close_frame();
      repeat (8) @(posedge clk_i);
      cs_n_o <= 1'b1;
      din_o  <= ~din_o;
   endtask : close_frame

   // one byte msb first: launch on rise, sample on fall
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         @(posedge clk_i);
         sclk_o <= 1'b1;
         din_o  <= tx[i];
         repeat (8) @(posedge clk_i);
         sclk_o <= 1'b0;
         rx[i]  = dout_i;
         repeat (7) @(posedge clk_i);
      end
   endtask : xfer
endmodule : spi_host_model

// ---- test/tb.sv ----
// Purpose: random register traffic against the config bank
// Assumes: host model speaks spi mode 1 at 160 ns per bit
// Notes:   expectations come from the bench tables only
`timescale 1ns/1ps
module tb;
   import adc_cfg_pkg::*;
   logic clk = 1'b0, rst = 1'b1, conv = 1'b0;   // clock, reset, conversion pulse
   wire  cs_n, sclk, din, dout, rdy_n, restart, lsw, pd, dout_oe, start;
   wire  [13:0] rate;
   wire  [9:0]  modk;
   wire  [10:0] exc;
   wire  [2:0]  rt1, rt2;
   wire  [1:0]  refs, mains;
   wire  cont, temp, burn, duty;
   int   failures = 0, checks_done = 0, restarts = 0, starts = 0;
   logic [31:0] seed = 32'h0000_0004;
   logic [7:0]  r1, r2, r3, rx;

   always #5 clk = ~clk;
   always @(posedge clk) if (restart === 1'b1) restarts++;
   always @(posedge clk) if (start === 1'b1) starts++;

   adc_config_registers uut (.CLOCK_I(clk), .RESET_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk),
      .DIN_I(din), .DOUT_O(dout), .DOUT_OE_O(dout_oe), .CONV_DONE_I(conv), .DATA_READY_N_O(rdy_n),
      .START_PULSE_O(start), .FILTER_RESTART_O(restart), .RATE_QSPS_O(rate), .MOD_CLK_KHZ_O(modk),
      .DUTY_CYCLE_O(duty), .CONTINUOUS_O(cont), .TEMP_SENSOR_O(temp), .BURNOUT_O(burn),
      .REF_SEL_O(refs), .MAINS_FILTER_O(mains), .LOW_SIDE_CLOSED_O(lsw),
      .EXC_CURRENT_UA_O(exc), .FIRST_ROUTE_O(rt1), .SECOND_ROUTE_O(rt2), .POWERED_DOWN_O(pd));
   spi_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // rate in quarter sps: normal, duty, turbo rows
   function automatic logic [31:0] rate_q(input logic [1:0] m, input logic [2:0] c);
      int t[3][7] = '{'{80, 180, 360, 700, 1320, 2400, 4000}, '{20, 45, 90, 176, 330, 600,
         1000}, '{160, 360, 720, 1400, 2640, 4800, 8000}};
      return (m == 2'h3 || c == 3'h7) ? 32'h0 : 32'(t[m][c]);
   endfunction : rate_q

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one-byte command in its own frame
   task automatic cmd(input logic [7:0] b);
      host.open_frame();
      host.xfer(b, rx);
      host.close_frame();
   endtask : cmd

   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // hang guard
   initial
   begin
      repeat (99000) @(posedge clk);
      failures++;
      tally_and_finish();
   end

   initial
   begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      chk(rate, 80);
      chk(modk, 256);
      chk(rdy_n, 1);
      for (int i = 0; i < 14; i++)
      begin
         seed = xs(seed);
         r1 = seed[7:0];
         r2 = seed[15:8];
         r3 = {seed[23:17], 1'b0};
         // corners: slowest normal, slowest duty, unused mode, fastest duty and turbo
         if (i == 0) r1[7:3] = 5'h00;
         if (i == 1) r1[7:3] = 5'h01;
         if (i == 2) r1[4:3] = 2'h3;
         if (i == 3) r1[7:3] = 5'h19;
         if (i == 4) r1[7:3] = 5'h1A;
         restarts = 0;
         starts = 0;
         host.open_frame();
         host.xfer(8'h46, rx);
         host.xfer(r1, rx);
         host.xfer(r2, rx);
         host.xfer(r3, rx);
         host.close_frame();
         chk(restarts, 1);
         repeat (4) @(posedge clk);
         chk(dout_oe, 0);
         cmd(8'h08);
         chk(starts, 1);
         chk(rate, rate_q(r1[4:3], r1[7:5]));
         chk(modk, r1[4:3] == 2'h3 ? 0 : (r1[4:3] == 2'h2 ? 512 : 256));
         chk(duty, r1[4:3] == 2'h1);
         chk({cont, temp, burn}, r1[2:0]);
         chk(refs, r2[7:6]);
         chk(mains, (r1[4] == 1'b0 && r1[7:5] == 3'h0) ? r2[5:4] : 0);
         chk(lsw, r2[3]);
         chk(exc, r2[2:0] < 2 ? 0 : (r2[2:0] < 4 ? 50 * (r2[2:0] - 1) : (r2[2:0] < 6 ?
            250 * (r2[2:0] - 3) : 1000 + 500 * (r2[2:0] - 6))));
         chk(rt1, r3[7:5] == 3'h7 ? 0 : r3[7:5]);
         chk(rt2, r3[4:2] == 3'h7 ? 0 : r3[4:2]);
         cmd(8'h02);
         chk({lsw, pd, exc}, {1'b0, 1'b1, 11'h000});
         host.open_frame();
         host.xfer(8'h27, rx);
         host.xfer(8'h00, rx);
         chk(rx, r1);
         host.xfer(8'h00, rx);
         chk(rx, r2);
         host.xfer(8'h00, rx);
         chk(rx, r3);
         host.xfer(8'h00, rx);
         chk(rx, 0);
         // conversion ready while selected
         @(posedge clk);
         conv <= 1'b1;
         @(posedge clk);
         conv <= 1'b0;
         repeat (4) @(posedge clk);
         chk({rdy_n, dout, dout_oe}, {1'b0, ~r3[1], 1'b1});
         host.xfer(8'h00, rx);
         repeat (4) @(posedge clk);
         chk(rdy_n, 1);
         host.close_frame();
      end
      tally_and_finish();
   end
endmodule : tb
